//--- logic/mfir_pkg.sv
// constants shared by the multi-function interrupt register bank
package mfir_pkg;

    localparam int          NREG       = 7;
    localparam int          NGRP       = 6;
    localparam int          EVT_W      = 26;
    localparam int          ADDR_W     = 6;
    localparam logic [7:0]  RST_REG    = 8'h00;
    localparam logic [5:0]  RST_GRP    = 6'h00;

    // register index 0 is the upper primary register, 1..6 groups 0..5
    localparam int          IDX_UPPER  = 0;
    localparam logic [6:0][5:0] REG_OFF = {
        6'h18, 6'h14, 6'h10, 6'h0C, 6'h08, 6'h04, 6'h00};
    localparam logic [5:0]  OFF_STATUS = 6'h1C;
    localparam logic [5:0]  OFF_MASK   = 6'h20;

    // upper primary register fields
    localparam int          UP_G5_FLAG = 7;
    localparam int          UP_G4_FLAG = 6;
    localparam int          UP_T4_FLAG = 5;
    localparam int          UP_T3_FLAG = 4;
    localparam int          UP_G5_EN   = 3;
    localparam int          UP_G4_EN   = 2;
    localparam int          UP_T4_EN   = 1;
    localparam int          UP_T3_EN   = 0;

    // implemented bits per register, unimplemented bits read zero
    localparam logic [6:0][7:0] IMPL_MASK = {
        8'h33, 8'hFF, 8'hFF, 8'h77, 8'hFF, 8'hFF, 8'hFF};
    // flag bits that a hardware event may set
    localparam logic [6:0][7:0] SET_MASK = {
        8'h30, 8'hA0, 8'hF0, 8'h70, 8'hE0, 8'hA0, 8'hF0};
    // registers present in the smaller and the larger variant
    localparam logic [6:0]  PRES_SMALL = 7'h1E;
    localparam logic [6:0]  PRES_LARGE = 7'h7F;

    typedef enum logic {
        MFIR_IDLE  = 1'b0,
        MFIR_RDWAIT = 1'b1
    } mfir_bus_t;

    // any source flag whose paired enable is set; flag 4+k pairs with k
    function automatic logic mfir_gated_any(
        input logic [7:0] r,
        input logic [7:0] m);
        mfir_gated_any = |(r[7:4] & r[3:0] & m[7:4]);
    endfunction : mfir_gated_any

endpackage : mfir_pkg

//--- logic/mfir_reg8.sv
// one 8-bit flag and enable register with hardware set inputs
`timescale 1ns/100ps
module mfir_reg8
    import mfir_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hFF,
    parameter logic [7:0] SETM = 8'h00
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] set_i,
    output logic      [7:0] q_o
);

    logic [7:0] set_bits;

    // only implemented, event-capable flags take a hardware set
    assign set_bits = set_i & SETM & IMPL;

    // a set in the same cycle as a software clear wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_o <= RST_REG;
        end else if (wr_en_i) begin
            q_o <= (wdata_i & IMPL) | set_bits;
        end else begin
            q_o <= q_o | set_bits;
        end
    end

endmodule : mfir_reg8

//--- logic/mfir_bank.sv
// multi-function interrupt register bank with an AHB-Lite slave
//
// Overview of operation
// R1: upper register: group 5 flag bit 7, enable bit 3, one is active.
// R2: upper register: group 4 flag bit 6, enable bit 2.
// R3: upper register: touch 4 and 3 flags bits 5,4; enables 1,0.
// R4: group 0 register: touch 1 counter 7/3, touch 0 counter 5/1.
// R5: software writes zero to reserved bits 6,4,2,0 of touch registers.
// R6: group 1 register: timer 0 A flag 7, P flag 6, enables 3,2.
// R7: group 1 register: touch 2 counter flag 5, enable 1.
// R8: group 2 register: timer 1 B, A, P flags 6..4, enables 2..0.
// R9: group 2 register bits 7 and 3 always read zero.
// R10: group 3 register flags: eeprom 7, low volt 6, ext 5, base 4.
// R11: group 3 register enables: eeprom 3, low volt 2, ext 1, base 0.
// R12: group 4 register: touch 4 counter 7/3, touch 3 counter 5/1.
// R13: upper, group 4 and group 5 registers exist in large variant only.
// R14: group 5 register: timer 2 A/P flags 5,4; bits 7,6,3,2 read zero.
// R15: a group flag sets when one of its source flags becomes set.
// R16: flags set regardless of enable; request needs enable and global.
// R17: all bits reset to zero and are freely read and written; unimplemented bits read zero and ignore writes.
// R18: registers for groups 0..5 feed groups 0..5, gated by enables.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module mfir_bank
    import mfir_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // ahb-lite slave
    input  wire logic             hsel_i,
    input  wire logic [ADDR_W-1:0] haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    // peripheral source events, one-cycle pulses
    input  wire logic [EVT_W-1:0] evt_i,
    // global enable from the lower primary registers
    input  wire logic             global_irq_en_i,
    // group 0..3 flag set pulses to the lower primary registers
    output logic      [3:0]       group_set_o,
    // requests: group5, group4, touch4, touch3
    output logic      [3:0]       cpu_req_o,
    output logic                  irq_o
);

    localparam logic [6:0] PRESENT = LARGE ? PRES_LARGE : PRES_SMALL;

    logic [NREG-1:0][7:0] regs;
    logic [NREG-1:0][7:0] set_vec;
    logic [NREG-1:0]      wr_en;
    logic [NGRP-1:0]      grp_any;
    logic [NGRP-1:0]      grp_any_d;
    logic [NGRP-1:0]      grp_rise;
    logic [NGRP-1:0]      status;
    logic [NGRP-1:0]      mask;
    logic [NGRP-1:0]      next_status;
    logic                 acc;
    logic                 dp_wr;
    logic                 dp_rd;
    logic [ADDR_W-1:0]    dp_addr;
    logic                 wr_now;
    logic [7:0]           wbyte;
    logic [31:0]          next_rdata;
    mfir_bus_t            bus_st;

    // address phase accepted when selected, active and bus ready
    assign acc    = hsel_i & htrans_i[1] & hready_i;
    assign wr_now = dp_wr & hready_i;
    assign wbyte  = hwdata_i[7:0];

    // data phase bookkeeping, reloaded whenever the bus is ready
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= '0;
        end else if (hready_i) begin
            dp_wr   <= acc & hwrite_i;
            dp_rd   <= acc & ~hwrite_i;
            dp_addr <= haddr_i;
        end
    end

    // reads take one wait state so they see completed writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_st <= MFIR_IDLE;
        end else begin
            unique case (bus_st)
                MFIR_IDLE: begin
                    if (dp_rd) begin
                        bus_st <= MFIR_RDWAIT;
                    end
                end
                MFIR_RDWAIT: begin
                    bus_st <= MFIR_IDLE;
                end
            endcase
        end
    end

    assign hreadyout_o = !(dp_rd && bus_st == MFIR_IDLE);
    assign hresp_o     = 1'b0;

    // read mux; absent registers and holes read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int r = 0; r < NREG; r++) begin
            if (dp_addr == REG_OFF[r] && PRESENT[r]) begin
                next_rdata[7:0] = regs[r]; // see R17
            end
        end
        if (dp_addr == OFF_STATUS) begin
            next_rdata[NGRP-1:0] = status;
        end
        if (dp_addr == OFF_MASK) begin
            next_rdata[NGRP-1:0] = mask;
        end
    end

    // read data loaded in the wait cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (dp_rd && bus_st == MFIR_IDLE) begin
            hrdata_o <= next_rdata;
        end
    end

    // write strobes; absent registers ignore writes
    always_comb begin
        for (int r = 0; r < NREG; r++) begin
            wr_en[r] = wr_now && dp_addr == REG_OFF[r]
                       && PRESENT[r]; // see R13
        end
    end

    // hardware set vectors: event k of a register sets flag bit 4+k
    always_comb begin
        set_vec[0] = {grp_rise[5], grp_rise[4],
                      evt_i[1:0], 4'h0}; // see R1 R2 R3 R15
        for (int r = 1; r < NREG; r++) begin
            set_vec[r] = {evt_i[4*r+1 -: 4], 4'h0}; // see R16
        end
        for (int r = 0; r < NREG; r++) begin
            set_vec[r] = set_vec[r] & {8{PRESENT[r]}};
        end
    end

    // register cells; masks place flags, enables and zero bits
    for (genvar r = 0; r < NREG; r++) begin : g_reg
        mfir_reg8 #(
            .IMPL (IMPL_MASK[r]),  // see R9 R14
            .SETM (SET_MASK[r])    // see R4 R6 R7 R8 R10 R11 R12
        ) u_reg (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .wr_en_i (wr_en[r]),
            .wdata_i (wbyte),      // reserved bits stored as written, see R5
            .set_i   (set_vec[r]),
            .q_o     (regs[r])
        );
    end

    // group g combines register g+1 flags gated by their enables
    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            grp_any[g] = mfir_gated_any(regs[g+1], SET_MASK[g+1])
                         & PRESENT[g+1]; // see R18
        end
    end

    assign grp_rise = grp_any & ~grp_any_d; // see R15

    // previous combined level for edge detection
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            grp_any_d <= RST_GRP;
        end else begin
            grp_any_d <= grp_any;
        end
    end

    // pulse lower group flags 0..3 when a group rises
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            group_set_o <= 4'h0;
        end else begin
            group_set_o <= grp_rise[3:0]; // see R15
        end
    end

    // upper sources request only with own enable and global enable
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cpu_req_o <= 4'h0;
        end else begin
            cpu_req_o <= {regs[IDX_UPPER][UP_G5_FLAG]
                              & regs[IDX_UPPER][UP_G5_EN],
                          regs[IDX_UPPER][UP_G4_FLAG]
                              & regs[IDX_UPPER][UP_G4_EN],
                          regs[IDX_UPPER][UP_T4_FLAG]
                              & regs[IDX_UPPER][UP_T4_EN],
                          regs[IDX_UPPER][UP_T3_FLAG]
                              & regs[IDX_UPPER][UP_T3_EN]}
                         & {4{global_irq_en_i}}; // see R16
        end
    end

    // sticky group status, write one to clear, set wins
    always_comb begin
        next_status = status;
        if (wr_now && dp_addr == OFF_STATUS) begin
            next_status = status & ~wbyte[NGRP-1:0];
        end
        next_status = next_status | grp_rise;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            status <= RST_GRP;
        end else begin
            status <= next_status;
        end
    end

    // interrupt mask register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mask <= RST_GRP;
        end else if (wr_now && dp_addr == OFF_MASK) begin
            mask <= wbyte[NGRP-1:0];
        end
    end

    // level interrupt while any unmasked status bit is set
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_status & mask);
        end
    end

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    grp2_zero_a : assert property ( // see R9
        (regs[3] & 8'h88) == 8'h00)
        else $error("group 2 register unimplemented bit set");

    grp5_zero_a : assert property ( // see R14
        (regs[6] & 8'hCC) == 8'h00)
        else $error("group 5 register unimplemented bit set");

    small_absent_a : assert property ( // see R13
        LARGE || (regs[0] == 8'h00 && regs[5] == 8'h00
                  && regs[6] == 8'h00))
        else $error("absent register holds a value");

    evt_flag_a : assert property ( // see R10
        evt_i[17] |=> regs[4][7])
        else $error("eeprom event did not set its flag");

    evt_noen_a : assert property ( // see R16
        evt_i[3] && !regs[1][1] |=> regs[1][5])
        else $error("disabled source flag not set");

    grp_upper_a : assert property ( // see R15
        $rose(grp_any[4]) |=> regs[0][6])
        else $error("group 4 flag not set on source rise");

    grp_pulse_a : assert property ( // see R18
        $rose(grp_any[0]) |=> group_set_o[0] ##1 !group_set_o[0])
        else $error("group 0 set pulse wrong");

    req_gate_a : assert property ( // see R1
        cpu_req_o[3] |-> $past(global_irq_en_i)
            && $past(regs[0][7]) && $past(regs[0][3]))
        else $error("group 5 request without enables");

    wr_store_a : assert property ( // see R17
        wr_en[4] && !(|evt_i[17:14]) |=> regs[4] == $past(wbyte))
        else $error("written value not stored");

    rd_wait_a : assert property (
        dp_rd && bus_st == MFIR_IDLE |-> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");

    irq_lvl_a : assert property (
        (status & mask) != 6'h00
            && !(wr_now && dp_addr == OFF_STATUS) |=> irq_o)
        else $error("interrupt not raised");

    // seven more sources set their own flag on the next edge
    tk3_set_a : assert property ( // see R3
        LARGE && evt_i[0] |=> regs[0][4])
        else $error("touch 3 event did not set its flag");

    tk2_set_a : assert property ( // see R7
        evt_i[7] |=> regs[2][5])
        else $error("touch 2 counter event did not set its flag");

    tmr0_set_a : assert property ( // see R6
        evt_i[9] |=> regs[2][7])
        else $error("timer 0 A event did not set its flag");

    tmr1_set_a : assert property ( // see R8
        evt_i[12] |=> regs[3][6])
        else $error("timer 1 B event did not set its flag");

    lowv_set_a : assert property ( // see R10
        evt_i[16] |=> regs[4][6])
        else $error("low voltage event did not set its flag");

    tk4_set_a : assert property ( // see R12
        LARGE && evt_i[21] |=> regs[5][7])
        else $error("touch 4 counter event did not set its flag");

    tmr2_set_a : assert property ( // see R14
        LARGE && evt_i[23] |=> regs[6][5])
        else $error("timer 2 A event did not set its flag");

    grp_gate_a : assert property ( // see R18
        grp_any[1] |-> (regs[2][7:5] & regs[2][3:1]) != 3'h0)
        else $error("group 1 active without an enabled flag");

    status_set_a : assert property ( // see R15
        grp_rise[2] |=> status[2])
        else $error("group 2 rise not recorded in status");

    status_clr_a : assert property (
        wr_now && dp_addr == OFF_STATUS && wbyte[0] && !grp_rise[0]
            |=> !status[0])
        else $error("status bit not cleared by writing one");

    req_touch_a : assert property ( // see R16
        cpu_req_o[0] |-> $past(global_irq_en_i)
            && $past(regs[0][4]) && $past(regs[0][0]))
        else $error("touch 3 request without enables");

    rd_hold_a : assert property (
        !(dp_rd && bus_st == MFIR_IDLE) |=> $stable(hrdata_o))
        else $error("read data changed outside a read");

    rd_cov_c  : cover property (dp_rd ##2 hreadyout_o);
    wr_cov_c  : cover property (wr_en[1]);
    irq_cov_c : cover property ($rose(irq_o));
    grp_cov_c : cover property (grp_rise[5]);
    req_cov_c : cover property (cpu_req_o[3]);

endmodule : mfir_bank

//--- verification/mfir_src_model.sv
// model of the peripheral event sources and the cpu sequencer enable
`timescale 1ns/100ps
module mfir_src_model
    import mfir_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [EVT_W-1:0] req_i,
    input  wire logic [3:0]       delay_i,
    input  wire logic             gie_i,
    output logic      [EVT_W-1:0] evt_o,
    output logic                  global_irq_en_o
);
    logic [EVT_W-1:0] pend;
    logic [3:0]       cnt;

    // hold a requested event for the asked delay, then pulse it once
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend  <= '0;
            cnt   <= 4'h0;
            evt_o <= '0;
        end else if (req_i != '0) begin
            pend  <= req_i;
            cnt   <= delay_i;
            evt_o <= '0;
        end else if (pend != '0 && cnt == 4'h0) begin
            evt_o <= pend;
            pend  <= '0;
        end else begin
            evt_o <= '0;
            cnt   <= cnt - 4'h1;
        end
    end

    // global enable as the sequencer sets it
    assign global_irq_en_o = gie_i;
endmodule : mfir_src_model

//--- verification/tb_top.sv
// self-checking testbench for the interrupt register bank
`timescale 1ns/100ps
module tb_top
    import mfir_pkg::*;
;
    // software write masks keep reserved touch bits zero
    localparam logic [6:0][7:0] WMSK = {8'hFF, 8'hAA, 8'hFF, 8'hFF,
        8'hEE, 8'hAA, 8'hFF};
    logic              clk_i, rst_n_i, hsel, hwrite, gie, gen, rd_ph;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic [31:0]       hwdata, hrdata;
    logic              hready, hresp, irq;
    logic [EVT_W-1:0]  req, evt;
    logic [3:0]        dly, gset, creq;
    logic [7:0]        expq[$];
    logic [7:0]        v;
    int                n_mismatch, n_checks, seed, c0;
    int                gs_cnt[4];

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    mfir_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .evt_i(evt), .global_irq_en_i(gen), .group_set_o(gset),
        .cpu_req_o(creq), .irq_o(irq));
    mfir_src_model u_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .delay_i(dly), .gie_i(gie), .evt_o(evt), .global_irq_en_o(gen));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // one ahb-lite single transfer, held until hready is sampled high
    task automatic bus(input logic [5:0] a, input logic w,
                       input logic [7:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk_i); while (hready !== 1'b1);
    endtask : bus

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(a, 1'b0, 8'h00);
    endtask : rd

    // ask the source model for an event and let it settle
    task automatic ev(input logic [EVT_W-1:0] e, input logic [3:0] d);
        req <= e;
        dly <= d;
        @(posedge clk_i);
        req <= '0;
        repeat (int'(d) + 6) @(posedge clk_i);
    endtask : ev

    // read data checker and group set pulse counter
    always @(posedge clk_i) begin
        if (rd_ph && hready === 1'b1) begin
            chk(hrdata, {24'h0, expq.pop_front()});
            chk({31'h0, hresp}, 32'h0);
        end
        if (!rst_n_i)
            rd_ph <= 1'b0;
        else if (hsel && htrans[1] && hready && !hwrite)
            rd_ph <= 1'b1;
        else if (hready)
            rd_ph <= 1'b0;
        for (int i = 0; i < 4; i++)
            if (gset[i] === 1'b1) gs_cnt[i]++;
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        results();
    end

    // main sequence
    initial begin
        seed = 23;
        n_mismatch = 0;
        n_checks = 0;
        gs_cnt = '{default: 0};
        rd_ph = 1'b0;
        rst_n_i = 1'b0;
        {hsel, htrans, haddr, hwrite, hwdata} = '0;
        {req, dly, gie} = '0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int r = 0; r < 9; r++) rd(6'(4 * r), 8'h00);
        bus(6'h24, 1'b1, 8'hFF);
        rd(6'h24, 8'h00);
        // random write and read back, upper register last
        for (int r = 6; r >= 0; r--) begin
            v = 8'($random(seed)) & WMSK[r];
            bus(REG_OFF[r], 1'b1, v);
            rd(REG_OFF[r], v & IMPL_MASK[r]);
        end
        for (int r = 0; r < 7; r++) bus(REG_OFF[r], 1'b1, 8'h00);
        bus(OFF_STATUS, 1'b1, 8'h3F);
        // every event sets its flag with enables clear, slow answers too
        for (int r = 1; r < 7; r++) begin
            ev(EVT_W'(4'hF) << (4 * r - 2), 4'(r));
            rd(REG_OFF[r], SET_MASK[r]);
            bus(REG_OFF[r], 1'b1, 8'h00);
        end
        ev(EVT_W'(2'h3), 4'h0);
        rd(6'h00, 8'h30);
        // group rise, status, interrupt and cpu requests
        bus(OFF_MASK, 1'b1, 8'h3F);
        bus(6'h00, 1'b1, 8'h0F);
        gie <= 1'b1;
        for (int g = 0; g < 6; g++) begin
            bus(REG_OFF[g + 1], 1'b1, 8'h0F & WMSK[g + 1]);
            c0 = (g < 4) ? gs_cnt[g] : 0;
            ev(EVT_W'(4'hF) << (4 * g + 2), 4'h0);
            chk({31'h0, irq}, 32'h1);
            rd(OFF_STATUS, 8'(1 << g));
            if (g < 4) begin
                chk(32'(gs_cnt[g] - c0), 32'h1);
            end else begin
                chk({28'h0, creq}, 32'(4'h4 << (g - 4)));
                rd(6'h00, 8'h0F | (8'h40 << (g - 4)));
                bus(6'h00, 1'b1, 8'h0F);
            end
            bus(OFF_STATUS, 1'b1, 8'(1 << g));
            bus(REG_OFF[g + 1], 1'b1, 8'h00);
            repeat (3) @(posedge clk_i);
            chk({31'h0, irq}, 32'h0);
        end
        // masked status holds the interrupt low until unmasked
        bus(OFF_MASK, 1'b1, 8'h00);
        bus(REG_OFF[4], 1'b1, 8'h0F);
        ev(EVT_W'(4'hF) << 14, 4'h2);
        chk({31'h0, irq}, 32'h0);
        bus(OFF_MASK, 1'b1, 8'h08);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        // cpu request waits for the global enable, source enable already set
        gie <= 1'b0;
        ev(EVT_W'(1'b1), 4'h0);
        chk({28'h0, creq}, 32'h0);
        gie <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({28'h0, creq}, 32'h1);
        results();
    end
endmodule : tb_top
